// ==== clock_source_control_pkg.sv ====
// Shared constants for the clock source control block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package clock_source_control_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 8;
    localparam int NUM_CHAN = 256;
    localparam int SRC_W = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FAST_START_TASK = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_FAST_STOP_TASK  = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_SLOW_START_TASK = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_SLOW_STOP_TASK  = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_SUB_BASE        = 12'h080;
    localparam logic [ADDR_W-1:0] OFF_SUB_LAST        = 12'h08C;
    localparam logic [ADDR_W-1:0] OFF_FAST_EVT        = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_SLOW_EVT        = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_FAST_PUB        = 12'h180;
    localparam logic [ADDR_W-1:0] OFF_SLOW_PUB        = 12'h184;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE      = 12'h300;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET  = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLR  = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_IRQ_PENDING     = 12'h30C;
    localparam logic [ADDR_W-1:0] OFF_FAST_RUN        = 12'h408;
    localparam logic [ADDR_W-1:0] OFF_FAST_STATE      = 12'h40C;
    localparam logic [ADDR_W-1:0] OFF_SLOW_RUN        = 12'h414;
    localparam logic [ADDR_W-1:0] OFF_SLOW_STATE      = 12'h418;
    localparam logic [ADDR_W-1:0] OFF_SLOW_LATCHED    = 12'h41C;
    localparam logic [ADDR_W-1:0] OFF_SLOW_SELECT     = 12'h518;

    // Field positions
    localparam int SUB_EN_BIT      = 31;
    localparam int PUB_EN_BIT      = 31;
    localparam int TASK_BIT        = 0;
    localparam int EVT_BIT         = 0;
    localparam int IRQ_FAST_BIT    = 0;
    localparam int IRQ_SLOW_BIT    = 1;
    localparam int RUN_BIT         = 0;
    localparam int FAST_SRC_BIT    = 0;
    localparam int STATE_BIT       = 16;

    // Reset values
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [SRC_W-1:0]  SRC_RESET  = 2'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    // Task indices
    localparam int TASK_FAST_START = 0;
    localparam int TASK_FAST_STOP  = 1;
    localparam int TASK_SLOW_START = 2;
    localparam int TASK_SLOW_STOP  = 3;
    localparam int NUM_TASKS       = 4;

    // Oscillator run states
    typedef enum logic [2:0] {
        OSC_OFF      = 3'b001,
        OSC_STARTING = 3'b010,
        OSC_RUNNING  = 3'b100
    } osc_state_t;

endpackage

// ==== clock_source_control.sv ====
// Clock source start/stop control with tasks, subscriptions and started events.
// Assumes an Avalon-MM master on clk, oscillator ready levels from another
// domain, and event channel pulses that are synchronous to clk.
`timescale 1ns/1ps

module clock_source_control
    import clock_source_control_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [NUM_CHAN-1:0] channel_in,
    input  wire logic                fast_crystal_ready,
    input  wire logic                slow_clock_ready,
    output logic                     fast_crystal_enable,
    output logic                     slow_clock_enable,
    output logic      [SRC_W-1:0]    slow_clock_source,
    output logic      [NUM_CHAN-1:0] channel_out,
    output logic                     irq
);

    // Register storage
    logic [DATA_W-1:0] sub_reg [NUM_TASKS];
    logic [DATA_W-1:0] fast_pub_reg;
    logic [DATA_W-1:0] slow_pub_reg;
    logic              fast_evt_reg;
    logic              slow_evt_reg;
    logic [1:0]        irq_enable_reg;
    logic              fast_run_reg;
    logic              slow_run_reg;
    logic [SRC_W-1:0]  slow_select_reg;
    logic [SRC_W-1:0]  slow_latched_reg;
    osc_state_t        fast_state_reg;
    osc_state_t        slow_state_reg;
    logic              fast_ready_meta_reg;
    logic              fast_ready_sync_reg;
    logic              slow_ready_meta_reg;
    logic              slow_ready_sync_reg;
    logic              ack_reg;

    // Bus decode helpers
    logic              wr_take;
    logic              rd_take;
    logic [DATA_W-1:0] wdata_masked;
    logic [NUM_TASKS-1:0] task_hit;
    logic              fast_started;
    logic              slow_started;
    logic [DATA_W-1:0] rdata_next;

    // Byte lanes applied to write data
    function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Subscription triggers when enabled and its channel is active
    function automatic logic sub_fire(input logic [DATA_W-1:0] sub,
                                      input logic [NUM_CHAN-1:0] ch);
        sub_fire = sub[SUB_EN_BIT] && ch[sub[CHAN_W-1:0]];
    endfunction

    // Task register address for index
    function automatic logic [ADDR_W-1:0] task_addr(input int idx);
        task_addr = OFF_FAST_START_TASK + ADDR_W'(idx * 4);
    endfunction

    // Accepted access: one wait cycle, answered on the next edge
    assign wr_take      = avs_write && ack_reg;
    assign rd_take      = avs_read && ack_reg;
    assign wdata_masked = avs_writedata & lane_mask(avs_byteenable);

    // Combined task trigger from bus write or subscribed channel
    always_comb
    begin
        for (int i = 0; i < NUM_TASKS; i++)
        begin
            task_hit[i] = (wr_take && avs_address == task_addr(i)
                           && wdata_masked[TASK_BIT])
                          || sub_fire(sub_reg[i], channel_in);
        end
    end

    // Started when starting and the synchronised ready is seen
    assign fast_started = fast_state_reg == OSC_STARTING && fast_ready_sync_reg;
    assign slow_started = slow_state_reg == OSC_STARTING && slow_ready_sync_reg;

    // Waitrequest handshake: low for one cycle per access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read || avs_write) && !ack_reg;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
    end

    // Ready synchronisers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_ready_meta_reg <= 1'b0;
            fast_ready_sync_reg <= 1'b0;
            slow_ready_meta_reg <= 1'b0;
            slow_ready_sync_reg <= 1'b0;
        end
        else
        begin
            fast_ready_meta_reg <= fast_crystal_ready;
            fast_ready_sync_reg <= fast_ready_meta_reg;
            slow_ready_meta_reg <= slow_clock_ready;
            slow_ready_sync_reg <= slow_ready_meta_reg;
        end
    end

    // Subscription registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NUM_TASKS; i++)
                sub_reg[i] <= RESET_WORD;
        end
        else if (wr_take)
        begin
            for (int i = 0; i < NUM_TASKS; i++)
            begin
                if (avs_address == OFF_SUB_BASE + ADDR_W'(i * 4))
                    sub_reg[i] <= (sub_reg[i] & ~lane_mask(avs_byteenable)) | wdata_masked;
            end
        end
    end

    // Publish configuration registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_pub_reg <= RESET_WORD;
            slow_pub_reg <= RESET_WORD;
        end
        else if (wr_take)
        begin
            if (avs_address == OFF_FAST_PUB)
                fast_pub_reg <= (fast_pub_reg & ~lane_mask(avs_byteenable)) | wdata_masked;
            else if (avs_address == OFF_SLOW_PUB)
                slow_pub_reg <= (slow_pub_reg & ~lane_mask(avs_byteenable)) | wdata_masked;
        end
    end

    // Published channel pulses on each started event
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel_out <= '0;
        else
        begin
            channel_out <= '0;
            if (fast_started && fast_pub_reg[PUB_EN_BIT])
                channel_out[fast_pub_reg[CHAN_W-1:0]] <= 1'b1;
            if (slow_started && slow_pub_reg[PUB_EN_BIT])
                channel_out[slow_pub_reg[CHAN_W-1:0]] <= 1'b1;
        end
    end

    // Started event flags: hardware set wins over software clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_evt_reg <= 1'b0;
            slow_evt_reg <= 1'b0;
        end
        else
        begin
            if (fast_started)
                fast_evt_reg <= 1'b1;
            else if (wr_take && avs_address == OFF_FAST_EVT && avs_byteenable[0])
                fast_evt_reg <= wdata_masked[EVT_BIT];
            if (slow_started)
                slow_evt_reg <= 1'b1;
            else if (wr_take && avs_address == OFF_SLOW_EVT && avs_byteenable[0])
                slow_evt_reg <= wdata_masked[EVT_BIT];
        end
    end

    // Interrupt enable with plain, set and clear views
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_enable_reg <= 2'h0;
        else if (wr_take && avs_byteenable[0])
        begin
            if (avs_address == OFF_IRQ_ENABLE)
                irq_enable_reg <= wdata_masked[IRQ_SLOW_BIT:IRQ_FAST_BIT];
            else if (avs_address == OFF_IRQ_ENABLE_SET)
                irq_enable_reg <= irq_enable_reg | wdata_masked[1:0];
            else if (avs_address == OFF_IRQ_ENABLE_CLR)
                irq_enable_reg <= irq_enable_reg & ~wdata_masked[1:0];
        end
    end

    // Interrupt output from flags gated by enables
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |({slow_evt_reg, fast_evt_reg} & irq_enable_reg);
    end

    // Source selection and its latched copy
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            slow_select_reg <= SRC_RESET;
        else if (wr_take && avs_address == OFF_SLOW_SELECT && avs_byteenable[0])
            slow_select_reg <= wdata_masked[SRC_W-1:0];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            slow_latched_reg <= SRC_RESET;
        else if (task_hit[TASK_SLOW_START])
            slow_latched_reg <= slow_select_reg;
    end

    // Run flags: set by start task, cleared by stop task
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_run_reg <= 1'b0;
            slow_run_reg <= 1'b0;
        end
        else
        begin
            if (task_hit[TASK_FAST_START])
                fast_run_reg <= 1'b1;
            else if (task_hit[TASK_FAST_STOP])
                fast_run_reg <= 1'b0;
            if (task_hit[TASK_SLOW_START])
                slow_run_reg <= 1'b1;
            else if (task_hit[TASK_SLOW_STOP])
                slow_run_reg <= 1'b0;
        end
    end

    // Fast oscillator sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fast_state_reg <= OSC_OFF;
        else if (task_hit[TASK_FAST_STOP])
            fast_state_reg <= OSC_OFF;
        else
        begin
            case (fast_state_reg)
                OSC_OFF:
                    if (task_hit[TASK_FAST_START])
                        fast_state_reg <= OSC_STARTING;
                OSC_STARTING:
                    if (fast_ready_sync_reg)
                        fast_state_reg <= OSC_RUNNING;
                OSC_RUNNING:
                    fast_state_reg <= OSC_RUNNING;
                default:
                    fast_state_reg <= OSC_OFF;
            endcase
        end
    end

    // Slow oscillator sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            slow_state_reg <= OSC_OFF;
        else if (task_hit[TASK_SLOW_STOP])
            slow_state_reg <= OSC_OFF;
        else
        begin
            case (slow_state_reg)
                OSC_OFF:
                    if (task_hit[TASK_SLOW_START])
                        slow_state_reg <= OSC_STARTING;
                OSC_STARTING:
                    if (slow_ready_sync_reg)
                        slow_state_reg <= OSC_RUNNING;
                OSC_RUNNING:
                    slow_state_reg <= OSC_RUNNING;
                default:
                    slow_state_reg <= OSC_OFF;
            endcase
        end
    end

    // Oscillator enables and selected source
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_crystal_enable <= 1'b0;
            slow_clock_enable   <= 1'b0;
            slow_clock_source   <= SRC_RESET;
        end
        else
        begin
            fast_crystal_enable <= fast_state_reg != OSC_OFF;
            slow_clock_enable   <= slow_state_reg != OSC_OFF;
            slow_clock_source   <= slow_latched_reg;
        end
    end

    // Read mux; task registers read zero
    always_comb
    begin
        rdata_next = UNMAPPED_READ;
        if (avs_address >= OFF_SUB_BASE && avs_address <= OFF_SUB_LAST)
            rdata_next = sub_reg[avs_address[3:2]];
        else if (avs_address == OFF_FAST_EVT)
            rdata_next[EVT_BIT] = fast_evt_reg;
        else if (avs_address == OFF_SLOW_EVT)
            rdata_next[EVT_BIT] = slow_evt_reg;
        else if (avs_address == OFF_FAST_PUB)
            rdata_next = fast_pub_reg;
        else if (avs_address == OFF_SLOW_PUB)
            rdata_next = slow_pub_reg;
        else if (avs_address == OFF_IRQ_ENABLE || avs_address == OFF_IRQ_ENABLE_SET
                 || avs_address == OFF_IRQ_ENABLE_CLR)
            rdata_next[IRQ_SLOW_BIT:IRQ_FAST_BIT] = irq_enable_reg;
        else if (avs_address == OFF_IRQ_PENDING)
            rdata_next[IRQ_SLOW_BIT:IRQ_FAST_BIT] =
                {slow_evt_reg, fast_evt_reg} & irq_enable_reg;
        else if (avs_address == OFF_FAST_RUN)
            rdata_next[RUN_BIT] = fast_run_reg;
        else if (avs_address == OFF_FAST_STATE)
        begin
            rdata_next[FAST_SRC_BIT] = fast_run_reg;
            rdata_next[STATE_BIT]    = fast_state_reg == OSC_RUNNING;
        end
        else if (avs_address == OFF_SLOW_RUN)
            rdata_next[RUN_BIT] = slow_run_reg;
        else if (avs_address == OFF_SLOW_STATE)
        begin
            rdata_next[SRC_W-1:0] = slow_latched_reg;
            rdata_next[STATE_BIT] = slow_state_reg == OSC_RUNNING;
        end
        else if (avs_address == OFF_SLOW_LATCHED)
            rdata_next[SRC_W-1:0] = slow_latched_reg;
        else if (avs_address == OFF_SLOW_SELECT)
            rdata_next[SRC_W-1:0] = slow_select_reg;
    end

    // Read data register, loaded in the wait cycle, on the edge that drops waitrequest
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= RESET_WORD;
        else if (avs_read && !ack_reg)
            avs_readdata <= rdata_next;
    end

endmodule

// ==== clock_source_control_sva.sv ====
// Port-level checker for the clock source control block.
// Assumes one clock domain and the one-wait-state bus answer of the block.
`timescale 1ns/1ps
module clock_source_control_sva
    import clock_source_control_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic [ADDR_W-1:0]   avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [DATA_W-1:0]   avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [DATA_W-1:0]   avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [NUM_CHAN-1:0] channel_in,
    input wire logic                fast_crystal_ready,
    input wire logic                slow_clock_ready,
    input wire logic                fast_crystal_enable,
    input wire logic                slow_clock_enable,
    input wire logic [SRC_W-1:0]    slow_clock_source,
    input wire logic [NUM_CHAN-1:0] channel_out,
    input wire logic                irq
);
    logic [SRC_W-1:0] sel_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Track the source selection as software writes it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sel_q <= SRC_RESET;
        else if (avs_write && !avs_waitrequest && avs_address == OFF_SLOW_SELECT
                 && avs_byteenable[0])
            sel_q <= avs_writedata[SRC_W-1:0];
    end

    // Accepted write of a 1 in bit 0 to one register
    sequence wr_one(logic [ADDR_W-1:0] a);
        avs_write && !avs_waitrequest && avs_address == a && avs_writedata[0]
            && avs_byteenable[0];
    endsequence
    sequence req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    AST_WAIT_ANSWER: assert property (req_seen |=> !avs_waitrequest)
        else $error("bus request not answered after one wait state");
    AST_WAIT_ONE_CYCLE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_NO_SPURIOUS: assert property (!avs_read && !avs_write && avs_waitrequest
        |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    AST_FAST_START: assert property
        (wr_one(OFF_FAST_START_TASK) |-> ##[1:3] fast_crystal_enable)
        else $error("fast start task did not enable the oscillator");
    AST_FAST_STOP: assert property
        (wr_one(OFF_FAST_STOP_TASK) |-> ##[1:3] !fast_crystal_enable)
        else $error("fast stop task did not disable the oscillator");
    AST_SLOW_START: assert property
        (wr_one(OFF_SLOW_START_TASK) |-> ##[1:3] slow_clock_enable)
        else $error("slow start task did not enable the source");
    AST_SLOW_STOP: assert property
        (wr_one(OFF_SLOW_STOP_TASK) |-> ##[1:3] !slow_clock_enable)
        else $error("slow stop task did not disable the source");
    AST_SLOW_SOURCE: assert property
        (wr_one(OFF_SLOW_START_TASK) |-> ##[1:3] slow_clock_source == sel_q)
        else $error("slow source output differs from selection at start");
    AST_IRQ_CLEAR: assert property
        (avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == OFF_IRQ_ENABLE_CLR && avs_writedata[1:0] == 2'h3 |-> ##[1:3] !irq)
        else $error("interrupt stays up after both enables cleared");
    AST_TASK_READ_ZERO: assert property
        (avs_read && !avs_waitrequest
        && avs_address <= OFF_SLOW_STOP_TASK |-> avs_readdata == RESET_WORD)
        else $error("task register read back nonzero");
endmodule

bind clock_source_control clock_source_control_sva chk (.clk, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .channel_in,
    .fast_crystal_ready, .slow_clock_ready, .fast_crystal_enable, .slow_clock_enable,
    .slow_clock_source, .channel_out, .irq);

// ==== clock_osc_model.sv ====
// Behavioural oscillators answering the block's enable outputs.
// Assumes enables are levels on clk; ready rises after a start-up delay.
`timescale 1ns/1ps
module clock_osc_model #(
    parameter int FAST_DELAY = 12,
    parameter int SLOW_DELAY = 30
)(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic fast_enable,
    input  wire logic slow_enable,
    output logic      fast_ready,
    output logic      slow_ready
);
    int fast_cnt;
    int slow_cnt;

    // Start-up counters; ready drops as soon as the source is switched off
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fast_cnt <= 0;
            slow_cnt <= 0;
            fast_ready <= 1'b0;
            slow_ready <= 1'b0;
        end
        else
        begin
            fast_cnt <= fast_enable ? fast_cnt + 1 : 0;
            slow_cnt <= slow_enable ? slow_cnt + 1 : 0;
            fast_ready <= fast_enable && fast_cnt >= FAST_DELAY;
            slow_ready <= slow_enable && slow_cnt >= SLOW_DELAY;
        end
    end
endmodule

// ==== clock_source_control_test.sv ====
// Self-checking bench for the clock source control block.
// Assumes the oscillator model on the far side and bus access by tasks.
`timescale 1ns/1ps
module clock_source_control_test;
    import clock_source_control_pkg::*;
    logic                clk;
    logic                rst_b;
    logic [ADDR_W-1:0]   avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [DATA_W-1:0]   avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic [NUM_CHAN-1:0] channel_in;
    logic                fast_ready;
    logic                slow_ready;
    logic                fast_en;
    logic                slow_en;
    logic [SRC_W-1:0]    slow_src;
    logic [NUM_CHAN-1:0] channel_out;
    logic                irq;
    logic [DATA_W-1:0]   d;
    int                  num_errors = 0;
    int                  checked = 0;
    int                  pub_cnt = 0;
    logic [ADDR_W-1:0]   zero_regs [9] = '{12'h000, 12'h080, 12'h084, 12'h100, 12'h300,
                                          12'h30C, 12'h408, 12'h418, 12'h200};

    clock_source_control uut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .channel_in(channel_in),
        .fast_crystal_ready(fast_ready), .slow_clock_ready(slow_ready),
        .fast_crystal_enable(fast_en), .slow_clock_enable(slow_en),
        .slow_clock_source(slow_src), .channel_out(channel_out), .irq(irq));
    clock_osc_model osc (.clk(clk), .rst_b(rst_b), .fast_enable(fast_en),
        .slow_enable(slow_en), .fast_ready(fast_ready), .slow_ready(slow_ready));

    // Clock generator, 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Count published pulses on channel 5
    always @(posedge clk)
        if (channel_out[5] === 1'b1) pub_cnt++;

    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus access; holds the request until waitrequest is sampled low
    task bus_access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        bus_access(1'b1, a, wd);
    endtask

    task rd(input logic [ADDR_W-1:0] a);
        bus_access(1'b0, a, RESET_WORD);
    endtask

    // Read until the expected value appears or the bound runs out
    task poll(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        do
        begin
            rd(a);
            n++;
        end
        while (d !== exp && n < 60);
    endtask

    task pulse(input int ch);
        @(posedge clk);
        channel_in[ch] <= 1'b1;
        @(posedge clk);
        channel_in[ch] <= 1'b0;
    endtask

    task summarize;
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        summarize();
    end

    // Main test sequence
    initial
    begin
        rst_b = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        channel_in = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            rd(zero_regs[i]);
            check(d, RESET_WORD);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_SUB_BASE + 12'(4 * i), 32'h8000_00F0 + i);
            rd(OFF_SUB_BASE + 12'(4 * i));
            check(d, 32'h8000_00F0 + i);
        end
        avs_byteenable <= 4'h1;
        wr(OFF_SUB_LAST, 32'hFFFF_FF55);
        avs_byteenable <= 4'hF;
        rd(OFF_SUB_LAST);
        check(d, 32'h8000_0055);
        wr(OFF_IRQ_ENABLE_SET, 32'h0000_0003);
        rd(OFF_IRQ_ENABLE);
        check(d, 32'h0000_0003);
        wr(OFF_IRQ_ENABLE_CLR, 32'h0000_0001);
        rd(OFF_IRQ_ENABLE_CLR);
        check(d, 32'h0000_0002);
        wr(OFF_IRQ_ENABLE, 32'h0000_0003);
        rd(OFF_IRQ_ENABLE_SET);
        check(d, 32'h0000_0003);
        wr(OFF_FAST_START_TASK, 32'h0000_0001);
        rd(OFF_FAST_RUN);
        check(d, 32'h0000_0001);
        rd(OFF_FAST_STATE);
        check(d, 32'h0000_0001);
        poll(OFF_FAST_EVT, 32'h0000_0001);
        check(d, 32'h0000_0001);
        rd(OFF_FAST_STATE);
        check(d, 32'h0001_0001);
        rd(OFF_IRQ_PENDING);
        check(d, 32'h0000_0001);
        check(irq, 1'b1);
        wr(OFF_FAST_EVT, RESET_WORD);
        rd(OFF_FAST_EVT);
        check(d, RESET_WORD);
        rd(OFF_IRQ_PENDING);
        check(d, RESET_WORD);
        check(irq, 1'b0);
        wr(OFF_SLOW_PUB, 32'h8000_0005);
        wr(OFF_SLOW_SELECT, 32'h0000_0002);
        wr(OFF_SLOW_START_TASK, 32'h0000_0001);
        wr(OFF_SLOW_SELECT, 32'h0000_0001);
        rd(OFF_SLOW_LATCHED);
        check(d, 32'h0000_0002);
        rd(OFF_SLOW_RUN);
        check(d, 32'h0000_0001);
        poll(OFF_SLOW_EVT, 32'h0000_0001);
        check(d, 32'h0000_0001);
        rd(OFF_SLOW_STATE);
        check(d, 32'h0001_0002);
        check(slow_src, 2'h2);
        check(pub_cnt, 1);
        wr(OFF_SUB_BASE, 32'h0000_0009);
        wr(OFF_SUB_BASE + 12'h004, 32'h8000_0007);
        pulse(7);
        rd(OFF_FAST_STATE);
        check(d, RESET_WORD);
        check(fast_en, 1'b0);
        pulse(9);
        rd(OFF_FAST_RUN);
        check(d, RESET_WORD);
        wr(OFF_SUB_BASE, 32'h8000_0009);
        pulse(9);
        rd(OFF_FAST_RUN);
        check(d, 32'h0000_0001);
        wr(OFF_SLOW_STOP_TASK, 32'h0000_0001);
        rd(OFF_SLOW_RUN);
        check(d, RESET_WORD);
        check(slow_en, 1'b0);
        wr(OFF_IRQ_ENABLE_CLR, 32'h0000_0003);
        rd(OFF_IRQ_ENABLE);
        check(d, RESET_WORD);
        check(irq, 1'b0);
        summarize();
    end
endmodule
